// file: include/adcc_pkg.sv
// Purpose: shared constants and carriers for the converter control block
// Assumes: 32-bit APB, byte offsets as listed below
// Notes: timing figures are held in their own units and converted here
package adcc_pkg;
  // register byte offsets
  localparam logic [15:0] CFG_OFS = 16'hD004;
  localparam logic [15:0] OFFSET_OFS = 16'hD008;
  localparam logic [15:0] GAIN_OFS = 16'hD00C;
  localparam logic [15:0] DMACTL_OFS = 16'hD010;
  localparam logic [15:0] DMASTAT_OFS = 16'hD014;
  localparam logic [15:0] BEG_OFS = 16'hD018;
  localparam logic [15:0] SIZE_OFS = 16'hD01C;
  localparam logic [15:0] FLAG_OFS = 16'hA810;
  localparam logic [15:0] EVEN_OFS = 16'hA850;
  localparam logic [15:0] TSET_OFS = 16'hA004;
  localparam logic [15:0] TCLR_OFS = 16'hA084;
  // reset values
  localparam logic [15:0] CFG_RST = 16'h1800;
  localparam logic [15:0] OFFSET_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'h8000;
  localparam logic [12:0] BEG_RST = 13'h0000;
  localparam logic [11:0] SIZE_RST = 12'h000;
  // field positions
  localparam int EV_OVF = 4;
  localparam int EV_SAT = 3;
  localparam int EV_FULL = 2;
  localparam int EV_HALF = 1;
  localparam int DMA_RST_BIT = 4;
  localparam int DMA_WRAP_BIT = 1;
  localparam int DMA_LOAD_BIT = 0;
  localparam int STAT_OVF = 1;
  localparam int STAT_ACT = 0;
  localparam int TOP_IRQ_BIT = 0;
  localparam logic [15:0] CFG_WMASK = 16'hFFFD;
  localparam logic [4:0] EV_MASK = 5'h1E;
  // timing: system clock and converter clocks in MHz, startup in us
  localparam int SYS_CLK_MHZ = 100;
  localparam int FAST_CLK_MHZ = 6;
  localparam int SLOW_CLK_MHZ = 1;
  localparam int FAST_DIV = SYS_CLK_MHZ / FAST_CLK_MHZ;
  localparam int SLOW_DIV = SYS_CLK_MHZ / SLOW_CLK_MHZ;
  localparam int STARTUP_US = 21;
  localparam int STARTUP_CYC = STARTUP_US * SYS_CLK_MHZ;
  localparam logic [13:0] BASE_CLOCKS = 14'h0020;

  // configuration word, laid out as the register
  typedef struct packed {
    logic [2:0] period;
    logic hv_p;
    logic hv_n;
    logic [3:0] mux_p;
    logic [3:0] mux_n;
    logic slow_clk;
    logic rsvd;
    logic enable;
  } adcc_cfg_s;

  // one write into system ram
  typedef struct packed {
    logic we;
    logic [12:0] addr;
    logic [15:0] data;
  } adcc_ram_wr_s;

  typedef enum logic [1:0] {
    CV_OFF = 2'b00,
    CV_WARM = 2'b01,
    CV_RUN = 2'b10
  } adcc_conv_e;
endpackage : adcc_pkg

// file: design/adcc_correct.sv
// Purpose: offset and gain correction of one raw result
// Assumes: one result in, one corrected result out a cycle later
// Notes: saturates to the signed 16-bit range and flags it
`timescale 1ns/1ps
module adcc_correct
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic in_valid, // raw result strobe
  input wire logic [15:0] raw, // raw signed result
  input wire logic [15:0] offset, // signed offset
  input wire logic [15:0] gain, // unsigned gain, 1.15 format
  output logic out_valid, // corrected result strobe
  output logic [15:0] result, // corrected result
  output logic sat // saturation pulse
);
  logic signed [16:0] sum;
  logic signed [33:0] prod;
  logic ovr;

  ////////////////////////////////////////////////////////////////////
  // offset added first
  // seventeen bits so the addition itself never wraps
  assign sum = $signed({raw[15], raw}) + $signed({offset[15], offset});
  assign prod = sum * $signed({1'b0, gain});
  assign ovr = (prod[33:30] != 4'h0) && (prod[33:30] != 4'hF);

  // registered result, clamped when out of range
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid <= 1'b0;
      result <= 16'h0000;
      sat <= 1'b0;
    end
    else
    begin
      out_valid <= in_valid;
      sat <= in_valid && ovr;
      if (in_valid)
        result <= !ovr ? prod[30:15] : (prod[33] ? 16'h8000 : 16'h7FFF);
    end
  end
endmodule : adcc_correct

// file: design/adcc_top.sv
// Purpose: converter control: config, timing, correction, result dma, events
// Assumes: analog front end supplies raw_result when conv_done pulses
// Notes: APB slave with one wait state; ram writes take one cycle
// How it works
// - one interrupt, gated by top set/clear
// - four event flags in one register
// - result while dma idle sets overflow
// - gain product out of range sets saturation
// - last buffer write sets full flag
// - last first-half write sets half flag
// - writing one clears a flag
// - only enabled flags raise interrupt
// - period field gives 32 shl n clocks
// - range bits select high or low range
// - positive input select four-bit code
// - negative select uses same code
// - clock bit picks 6 or 1 MHz
// - enable starts; first conversion doubled plus startup
// - config change doubles next conversion
// - signed offset added before gain
// - unsigned 1.15 gain multiplies result
// - dma reset clears overflow and load
// - wrap bit: stop or wrap when full
// - buffer size counts 16-bit results
// - buffer start address forced even
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int STARTUP_CYCLES = adcc_pkg::STARTUP_CYC // analog warm-up in cycles
)
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [15:0] raw_result, // raw result from analog side
  output adcc_pkg::adcc_cfg_s analog_cfg, // settings to analog side
  output logic conv_done, // end of conversion pulse
  output adcc_pkg::adcc_ram_wr_s ram_wr, // result write to ram
  output logic irq // converter interrupt request
);
  import adcc_pkg::*;

  adcc_cfg_s cfg;
  logic [15:0] offset;
  logic [15:0] gain;
  logic [12:0] beg;
  logic [11:0] size;
  logic [4:0] flags;
  logic [4:0] enables;
  logic top_en;
  logic dma_active;
  logic dma_load;
  logic dma_wrap;
  logic dma_ovf;
  logic [11:0] cnt;
  adcc_conv_e conv_state;
  logic [6:0] pre;
  logic tick;
  logic [14:0] scnt;
  logic dbl;
  logic [11:0] stc;
  logic [14:0] target;
  logic wr;
  logic rd_phase;
  logic cfg_wr;
  logic rst_wr;
  logic cv;
  logic [15:0] cres;
  logic csat;
  logic [4:0] ev;
  logic [4:0] clr;
  logic last;
  logic half;
  logic mapped;
  logic [31:0] rmux;

  ////////////////////////////////////////////////////////////////////
  // apb decode; writes act only at the completing edge
  assign wr = psel && penable && pready && pwrite;
  assign rd_phase = psel && penable && !pready;
  assign cfg_wr = wr && (paddr == CFG_OFS);
  assign rst_wr = wr && (paddr == DMACTL_OFS) && pwdata[DMA_RST_BIT];
  assign mapped = (paddr == CFG_OFS) || (paddr == OFFSET_OFS) || (paddr == GAIN_OFS)
    || (paddr == DMACTL_OFS) || (paddr == DMASTAT_OFS) || (paddr == BEG_OFS)
    || (paddr == SIZE_OFS) || (paddr == FLAG_OFS) || (paddr == EVEN_OFS)
    || (paddr == TSET_OFS) || (paddr == TCLR_OFS);

  // read mux; reserved bits read zero
  always_comb
  begin
    rmux = 32'h0000_0000;
    case (paddr)
      CFG_OFS: rmux = {16'h0000, cfg};
      OFFSET_OFS: rmux = {16'h0000, offset};
      GAIN_OFS: rmux = {16'h0000, gain};
      DMACTL_OFS: rmux = {30'h0000_0000, dma_wrap, dma_load};
      DMASTAT_OFS: rmux = {30'h0000_0000, dma_ovf, dma_active};
      BEG_OFS: rmux = {19'h00000, beg};
      SIZE_OFS: rmux = {20'h00000, size};
      FLAG_OFS: rmux = {27'h0000000, flags};
      EVEN_OFS: rmux = {27'h0000000, enables};
      TSET_OFS: rmux = {31'h0000_0000, top_en};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // one wait state so every answer comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rd_phase;
      pslverr <= rd_phase && !mapped;
      if (rd_phase && !pwrite)
        prdata <= rmux;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration and correction registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= CFG_RST;
      offset <= OFFSET_RST;
      gain <= GAIN_RST;
      beg <= BEG_RST;
      size <= SIZE_RST;
      enables <= 5'h00;
      top_en <= 1'b0;
    end
    else if (wr)
    begin
      // range, input codes, clock pick
      // the reserved bit is dropped rather than stored
      if (paddr == CFG_OFS)
        cfg <= pwdata[15:0] & CFG_WMASK;
      if (paddr == OFFSET_OFS)
        offset <= pwdata[15:0];
      if (paddr == GAIN_OFS)
        gain <= pwdata[15:0];
      if (paddr == BEG_OFS)
        beg <= {pwdata[12:1], 1'b0};
      if (paddr == SIZE_OFS)
        size <= pwdata[11:0];
      if (paddr == EVEN_OFS)
        enables <= pwdata[4:0] & EV_MASK;
      if (paddr == TSET_OFS && pwdata[TOP_IRQ_BIT])
        top_en <= 1'b1;
      if (paddr == TCLR_OFS && pwdata[TOP_IRQ_BIT])
        top_en <= 1'b0;
    end
  end

  // settings go out as a registered copy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      analog_cfg <= CFG_RST;
    else
      analog_cfg <= cfg;
  end

  ////////////////////////////////////////////////////////////////////
  // converter clock ticks from a divider of the system clock
  // tick rate from clock bit
  // compare with >= so a switch from slow to fast mid-count cannot miss the tick
  assign tick = cfg.slow_clk ? (pre >= 7'(SLOW_DIV - 1)) : (pre >= 7'(FAST_DIV - 1));
  assign target = dbl ? {BASE_CLOCKS << cfg.period, 1'b0} : {1'b0, BASE_CLOCKS << cfg.period};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre <= 7'h00;
    else if (conv_state != CV_RUN || tick)
      pre <= 7'h00;
    else
      pre <= pre + 7'h01;
  end

  // conversion sequencer: warm-up, then back-to-back conversions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv_state <= CV_OFF;
      scnt <= 15'h0000;
      stc <= 12'h000;
      dbl <= 1'b0;
      conv_done <= 1'b0;
    end
    else
    begin
      conv_done <= 1'b0;
      case (conv_state)
        CV_OFF:
        begin
          // start with warm-up and doubled first conversion
          if (cfg.enable)
          begin
            conv_state <= CV_WARM;
            stc <= 12'h000;
            dbl <= 1'b1;
          end
        end
        CV_WARM:
        begin
          if (!cfg.enable)
            conv_state <= CV_OFF;
          else if (stc == 12'(STARTUP_CYCLES - 1))
          begin
            conv_state <= CV_RUN;
            scnt <= 15'h0000;
          end
          else
            stc <= stc + 12'h001;
        end
        CV_RUN:
        begin
          if (!cfg.enable)
            conv_state <= CV_OFF;
          else if (cfg_wr)
          begin
            dbl <= 1'b1;
            scnt <= 15'h0000;
          end
          else if (tick && scnt == target - 15'h0001)
          begin
            conv_done <= 1'b1;
            scnt <= 15'h0000;
            dbl <= 1'b0;
          end
          else if (tick)
            scnt <= scnt + 15'h0001;
        end
        default:
          conv_state <= CV_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // correction stage, fed by the result taken at end of conversion
  adcc_correct u_correct
  (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(conv_done),
    .raw(raw_result),
    .offset(offset),
    .gain(gain),
    .out_valid(cv),
    .result(cres),
    .sat(csat)
  );

  ////////////////////////////////////////////////////////////////////
  // result dma
  // final location
  assign last = (size != 12'h000) && (cnt == size - 12'h001);
  assign half = (size > 12'h001) && (cnt == (size >> 1) - 12'h001);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_active <= 1'b0;
      dma_load <= 1'b0;
      dma_wrap <= 1'b0;
      dma_ovf <= 1'b0;
      cnt <= 12'h000;
      ram_wr <= '0;
    end
    else
    begin
      ram_wr.we <= 1'b0;
      if (wr && paddr == DMACTL_OFS)
        dma_wrap <= pwdata[DMA_WRAP_BIT];
      if (rst_wr)
      begin
        dma_active <= 1'b0;
        dma_load <= 1'b0;
        dma_ovf <= 1'b0;
        cnt <= 12'h000;
      end
      else
      begin
        if (wr && paddr == DMACTL_OFS && pwdata[DMA_LOAD_BIT])
          dma_load <= 1'b1;
        else if (dma_load && !dma_active)
        begin
          dma_load <= 1'b0;
          dma_active <= 1'b1;
          cnt <= 12'h000;
        end
        if (cv && dma_active)
        begin
          ram_wr.we <= 1'b1;
          ram_wr.addr <= beg + {cnt, 1'b0};
          ram_wr.data <= cres;
          if (last)
          begin
            cnt <= 12'h000;
            dma_active <= dma_wrap;
          end
          else
            cnt <= cnt + 12'h001;
        end
      end
      // overflow while inactive; a result in the reset cycle still counts
      if (cv && !dma_active)
        dma_ovf <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // event flags; an event in the clearing cycle survives
  // overflow, saturation, full, half
  assign ev = {cv && !dma_active, csat, cv && dma_active && last,
    cv && dma_active && half, 1'b0};
  assign clr = (wr && paddr == FLAG_OFS) ? pwdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags <= 5'h00;
    else
      flags <= ((flags & ~clr) | ev) & EV_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= top_en && ((flags & enables) != 5'h00);
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  ovf_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    cv && !dma_active |=> flags[EV_OVF] && dma_ovf)
    else $error("overflow not flagged");
  sat_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done ##1 csat |=> flags[EV_SAT])
    else $error("saturation not flagged");
  full_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    cv && dma_active && last && !rst_wr |=> flags[EV_FULL] && cnt == 12'h000)
    else $error("full not flagged");
  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == FLAG_OFS && pwdata[EV_HALF] && !ev[EV_HALF] |=> !flags[EV_HALF])
    else $error("flag not cleared");
  irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> $past(top_en) && (($past(flags) & $past(enables)) != 5'h00))
    else $error("irq without enabled flag");
  warm_up_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_state == CV_OFF && cfg.enable |=> conv_state == CV_WARM ##1 !conv_done [*8])
    else $error("warm-up skipped");
  dma_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_wr && !(cv && !dma_active) |=> !dma_active && !dma_load && !dma_ovf)
    else $error("dma reset incomplete");
  linear_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    cv && dma_active && last && !dma_wrap |=> !dma_active)
    else $error("linear dma did not stop");
  load_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    dma_load && !dma_active && !wr |=> dma_active && !dma_load)
    else $error("load did not start dma");
  even_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    ram_wr.we |-> !ram_wr.addr[0])
    else $error("odd ram address");
endmodule : adcc_top

// file: verification/adcc_ram_model.sv
// Purpose: system ram on the far side of the result dma
// Assumes: one half-word write for each we pulse
// Notes: keeps the last write and a count, which is all the bench needs
`timescale 1ns/1ps
module adcc_ram_model
  import adcc_pkg::*;
(
  input wire logic pclk, // system clock
  input wire adcc_pkg::adcc_ram_wr_s ram_wr // write from the dma
);
  logic [12:0] last_addr;
  logic [15:0] last_data;
  int wr_count = 0;
  // take the write at its pulse; a full array would only cost run time
  always @(posedge pclk)
  begin
    if (ram_wr.we === 1'b1)
    begin
      last_addr <= ram_wr.addr;
      last_data <= ram_wr.data;
      wr_count <= wr_count + 1;
    end
  end
endmodule : adcc_ram_model

// file: verification/tb.sv
// Purpose: self-checking bench for the converter control block
// Assumes: raw results come from the bench, warm-up shortened to 20 cycles
// Notes: conversion timing is checked inside small windows
`timescale 1ns/1ps
module tb;
  import adcc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] raw_result = 16'h0000;
  adcc_cfg_s analog_cfg;
  adcc_ram_wr_s ram_wr;
  logic conv_done;
  logic irq;
  int err_count = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic er;
  int n;
  // free-running system clock
  always #5 pclk = ~pclk;
  adcc_top #(.STARTUP_CYCLES(20)) u_adcc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .raw_result(raw_result), .analog_cfg(analog_cfg),
    .conv_done(conv_done), .ram_wr(ram_wr), .irq(irq));
  adcc_ram_model u_adcc_ram_model (.pclk(pclk), .ram_wr(ram_wr));
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic timeout();
    err_count++;
    $display("unexpected at %0t: wait ran out", $time);
    summarize();
  endtask : timeout
  // one apb transfer; held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
      timeout();
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdc
  task automatic idle(input int k);
    repeat (k) @(posedge pclk);
  endtask : idle
  // cycles to the next conversion end must fall in lo..hi
  task automatic wait_conv(input int lo, input int hi);
    for (n = 1; n <= hi; n++)
    begin
      @(posedge pclk);
      if (conv_done === 1'b1)
        break;
    end
    if (n > hi)
      timeout();
    chk((n >= lo) ? lo : n, lo);
  endtask : wait_conv
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(analog_cfg, 32'h1800);
    rdc(CFG_OFS, 32'h1800);
    rdc(OFFSET_OFS, 32'h0);
    rdc(GAIN_OFS, 32'h8000);
    rdc(DMACTL_OFS, 32'h0);
    wr(DMASTAT_OFS, 32'h3);
    rdc(DMASTAT_OFS, 32'h0);
    rdc(FLAG_OFS, 32'h0);
    rdc(16'hD0F0, 32'h0);
    chk(er, 1'b1);
  endtask : t_reset
  // range, both mux codes and clock bit reach the analog side
  task automatic t_cfg();
    wr(CFG_OFS, 32'h15D4);
    rdc(CFG_OFS, 32'h15D4);
    idle(2);
    chk(analog_cfg, 32'h15D4);
    chk(analog_cfg.slow_clk, 1'b1);
    chk(analog_cfg.hv_p, 1'b1);
    wr(CFG_OFS, 32'h0);
    // period code 1: 64 ticks, doubled for the first result
    wr(CFG_OFS, 32'h2001);
    wait_conv(2060, 2080);
    wait_conv(1022, 1026);
    wr(CFG_OFS, 32'h0);
  endtask : t_cfg
  // timing, overflow with dma idle, interrupt gating and clearing
  task automatic t_conv_irq();
    raw_result <= 16'h0100;
    wr(EVEN_OFS, 32'h10);
    wr(TSET_OFS, 32'h1);
    wr(CFG_OFS, 32'h1);
    wait_conv(1036, 1052);
    wait_conv(510, 514);
    wr(CFG_OFS, 32'h5);
    wait_conv(6390, 6410);
    wait_conv(3195, 3205);
    wr(CFG_OFS, 32'h0);
    idle(4);
    rdc(FLAG_OFS, 32'h10);
    rdc(DMASTAT_OFS, 32'h2);
    chk(irq, 1'b1);
    wr(TCLR_OFS, 32'h1);
    idle(3);
    chk(irq, 1'b0);
    wr(TSET_OFS, 32'h1);
    idle(3);
    chk(irq, 1'b1);
    wr(EVEN_OFS, 32'h0);
    idle(3);
    chk(irq, 1'b0);
    wr(FLAG_OFS, 32'h0E);
    rdc(FLAG_OFS, 32'h10);
    wr(FLAG_OFS, 32'h10);
    rdc(FLAG_OFS, 32'h0);
    wr(DMACTL_OFS, 32'h10);
    rdc(DMASTAT_OFS, 32'h0);
  endtask : t_conv_irq
  // linear two-entry buffer: half, full, stop, then overflow
  task automatic t_dma();
    raw_result <= 16'h2000;
    wr(OFFSET_OFS, 32'hF000);
    wr(GAIN_OFS, 32'h4000);
    wr(BEG_OFS, 32'h0101);
    rdc(BEG_OFS, 32'h0100);
    wr(SIZE_OFS, 32'h2);
    wr(FLAG_OFS, 32'h1E);
    wr(EVEN_OFS, 32'h06);
    wr(DMACTL_OFS, 32'h1);
    rdc(DMACTL_OFS, 32'h0);
    rdc(DMASTAT_OFS, 32'h1);
    wr(FLAG_OFS, 32'h10);
    wr(CFG_OFS, 32'h1);
    wait_conv(1036, 1052);
    idle(4);
    chk(u_adcc_ram_model.last_addr, 13'h0100);
    chk(u_adcc_ram_model.last_data, 16'h0800);
    rdc(FLAG_OFS, 32'h02);
    chk(irq, 1'b1);
    wait_conv(480, 514);
    idle(4);
    chk(u_adcc_ram_model.last_addr, 13'h0102);
    rdc(FLAG_OFS, 32'h06);
    rdc(DMASTAT_OFS, 32'h0);
    wait_conv(1, 514);
    idle(4);
    rdc(FLAG_OFS, 32'h16);
    chk(u_adcc_ram_model.wr_count, 32'h2);
    wr(CFG_OFS, 32'h0);
  endtask : t_dma
  // wrap mode, one-entry buffer, positive saturation
  task automatic t_sat();
    wr(DMACTL_OFS, 32'h10);
    wr(OFFSET_OFS, 32'h0);
    wr(GAIN_OFS, 32'hFFFF);
    raw_result <= 16'h7000;
    wr(BEG_OFS, 32'h0200);
    wr(SIZE_OFS, 32'h1);
    wr(FLAG_OFS, 32'h1E);
    wr(DMACTL_OFS, 32'h3);
    wr(CFG_OFS, 32'h1);
    wait_conv(1036, 1052);
    wait_conv(510, 514);
    idle(4);
    chk(u_adcc_ram_model.last_addr, 13'h0200);
    chk(u_adcc_ram_model.last_data, 16'h7FFF);
    chk(u_adcc_ram_model.wr_count, 32'h4);
    rdc(FLAG_OFS, 32'h0C);
    rdc(DMASTAT_OFS, 32'h1);
    wr(CFG_OFS, 32'h0);
  endtask : t_sat
  //////////////////////////////////////////////////////////////////////////////
  // reset for 16 cycles, then the scenarios in turn
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cfg();
    t_conv_irq();
    t_dma();
    t_sat();
    summarize();
  end
endmodule : tb
